/* File: pkg/bt16_consts.svh */
/*
 register offsets, field positions, reset values and timing counts of the 16-bit timer.
 assumes inclusion by bare name from design files.
*/
`ifndef BT16_CONSTS_SVH
`define BT16_CONSTS_SVH
`define BT16_OFF_CONTROL   8'h00
`define BT16_OFF_PERIOD    8'h04
`define BT16_OFF_COUNT     8'h08
`define BT16_OFF_STATUS    8'h0C
`define BT16_OFF_MASK      8'h10
`define BT16_OFF_POWER     8'h14
`define BT16_BIT_ON        15
`define BT16_BIT_SIDL      13
`define BT16_BIT_ECS_HI    9
`define BT16_BIT_ECS_LO    8
`define BT16_BIT_GATE      6
`define BT16_BIT_PS_HI     5
`define BT16_BIT_PS_LO     4
`define BT16_BIT_SYNC      2
`define BT16_BIT_CS        1
`define BT16_CONTROL_MASK  16'hA376
`define BT16_CONTROL_RST   16'h0000
`define BT16_PERIOD_RST    16'hFFFF
`define BT16_ST_MATCH      0
`define BT16_ST_GATE       1
`define BT16_DIV_8         8
`define BT16_DIV_64        64
`define BT16_DIV_256       256
`endif

/* File: pkg/bt16_pkg.sv */
/*
 types of the 16-bit timer: clock source codes, prescale codes, control fields.
 assumes nothing beyond a SystemVerilog compiler.
*/
package bt16_pkg;
   typedef enum logic [1:0] {
      BT16_SRC_SECONDARY = 2'h0,
      BT16_SRC_EXTPIN    = 2'h1,
      BT16_SRC_LOW_POWER_RC_OSC      = 2'h2,
      BT16_SRC_RESERVED  = 2'h3
   } bt16_src_t;

   typedef enum logic [1:0] {
      BT16_PS_1   = 2'h0,
      BT16_PS_8   = 2'h1,
      BT16_PS_64  = 2'h2,
      BT16_PS_256 = 2'h3
   } bt16_ps_t;

   typedef struct packed {
      logic      count_on;
      logic      stop_in_idle;
      bt16_src_t ext_clock_select;
      logic      gate_accumulate_en;
      bt16_ps_t  prescale_select;
      logic      ext_clock_sync;
      logic      clock_source_select;
   } bt16_ctrl_t;

   typedef enum logic [2:0] {
      BT16_RD_IDLE = 3'b001,
      BT16_RD_RESP = 3'b010,
      BT16_RD_HOLD = 3'b100
   } bt16_rd_state_t;
endpackage

/* File: design/bt16_edge_sync.sv */
/*
 three-stage synchroniser with rising and falling event detection for one pin.
 assumes the pin is asynchronous to aclk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module bt16_edge_sync (
   input  wire logic aclk,    // system clock
   input  wire logic aresetn, // synchronous reset, active low
   input  wire logic pin,     // asynchronous input
   output logic      level,   // filtered level
   output logic      rise,    // one-cycle rise pulse
   output logic      fall     // one-cycle fall pulse
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   always_comb begin
      next_stage = {stage[1:0], pin};
      next_level = level;
      // a change counts only once stages two and three agree
      if (stage[2] == stage[1]) begin
         next_level = stage[2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage <= 3'h0;
         level <= 1'b0;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end

   assign rise = next_level & ~level;
   assign fall = ~next_level & level;
endmodule
`default_nettype wire

/* File: design/bt16_timer.sv */
/*
 16-bit interval timer/counter with AXI4-Lite register slave and level interrupt.
 assumes one 50 MHz clock; external clock sources and gate arrive as asynchronous pins.
*/
// Summary of operation
// RULE1: one 16-bit counter runs as timer, synchronous counter or asynchronous counter per source and sync bits.
// RULE2: the interrupt is raised on a period match or, in gated mode, on the falling edge of the gate.
// RULE3: the counter keeps running in idle and sleep unless told otherwise; the code halts it in sleep unless counting asynchronously.
// RULE4: control bit 15 starts counting when 1 and stops it when 0.
// RULE5: with bit 13 set the block halts while the device is idle, otherwise it runs on.
// RULE6: bits 9-8 choose secondary oscillator, external pin or low-power RC; code 11 is reserved.
// RULE7: the extended clock select field counts only while the clock source select bit is 1.
// RULE8: with source select 0, bit 6 enables gated accumulation; with source select 1 it is ignored.
// RULE9: bits 5-4 give prescale 1:1, 1:8, 1:64 or 1:256.
// RULE10: with source select 1, bit 2 synchronises the external clock; with source select 0 it is ignored.
// RULE11: bit 1 picks the internal clock at half the oscillator rate when 0, else the extended selection.
// RULE12: software sets on, prescale, source and gating, sync, then period, then interrupt enables.
// RULE13: a software-written period register is compared with the running count.
// RULE14: control bits 14, 12-10, 7, 3 and 0 read zero and ignore writes.
// RULE15: all implemented control fields are read/write and clear to zero at reset.
// RULE16: each prescaled tick increments the count; on a period match it wraps to zero next tick and flags.
// RULE17: gated mode counts the internal clock while the gate is high and flags when the gate falls.
`timescale 1ns/1ps
`default_nettype none
`include "bt16_consts.svh"
module bt16_timer (
   input  wire logic        aclk,               // 50 MHz system clock
   input  wire logic        aresetn,            // synchronous reset, active low
   input  wire logic        cpu_idle,           // device in idle mode
   input  wire logic        cpu_sleep,          // device in sleep mode
   input  wire logic        secondary_osc,      // secondary oscillator input
   input  wire logic        external_clock_pin, // external clock pin
   input  wire logic        low_power_rc_osc,   // low-power rc oscillator
   input  wire logic        gate_pin,           // external gate input
   input  wire logic [7:0]  s_axi_awaddr,       // write address
   input  wire logic        s_axi_awvalid,      // write address valid
   output logic             s_axi_awready,      // write address ready
   input  wire logic [31:0] s_axi_wdata,        // write data
   input  wire logic [3:0]  s_axi_wstrb,        // write byte strobes
   input  wire logic        s_axi_wvalid,       // write data valid
   output logic             s_axi_wready,       // write data ready
   output logic [1:0]       s_axi_bresp,        // write response
   output logic             s_axi_bvalid,       // write response valid
   input  wire logic        s_axi_bready,       // write response ready
   input  wire logic [7:0]  s_axi_araddr,       // read address
   input  wire logic        s_axi_arvalid,      // read address valid
   output logic             s_axi_arready,      // read address ready
   output logic [31:0]      s_axi_rdata,        // read data
   output logic [1:0]       s_axi_rresp,        // read response
   output logic             s_axi_rvalid,       // read data valid
   input  wire logic        s_axi_rready,       // read data ready
   output logic             irq                 // level interrupt
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [8:0] ps_limit(input bt16_pkg::bt16_ps_t ps);
      case (ps)
         bt16_pkg::BT16_PS_8:   ps_limit = 9'(`BT16_DIV_8 - 1);
         bt16_pkg::BT16_PS_64:  ps_limit = 9'(`BT16_DIV_64 - 1);
         bt16_pkg::BT16_PS_256: ps_limit = 9'(`BT16_DIV_256 - 1);
         default:               ps_limit = 9'h000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic secondary_osc_rise, ext_rise, low_power_rc_osc_rise, gate_level, gate_fall;
   logic ext_raw_q, ext_raw_qq, ext_raw_qqq;

   bt16_edge_sync u_secondary_osc (.aclk(aclk), .aresetn(aresetn), .pin(secondary_osc),
                          .level(), .rise(secondary_osc_rise), .fall());
   bt16_edge_sync u_ext  (.aclk(aclk), .aresetn(aresetn), .pin(external_clock_pin),
                          .level(), .rise(ext_rise), .fall());
   bt16_edge_sync u_low_power_rc_osc (.aclk(aclk), .aresetn(aresetn), .pin(low_power_rc_osc),
                          .level(), .rise(low_power_rc_osc_rise), .fall());
   bt16_edge_sync u_gate (.aclk(aclk), .aresetn(aresetn), .pin(gate_pin),
                          .level(gate_level), .rise(), .fall(gate_fall));

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   bt16_pkg::bt16_ctrl_t ctrl, next_ctrl;
   logic [15:0] period_value, next_period_value;
   logic [15:0] count, next_count;
   logic [8:0]  ps_cnt, next_ps_cnt;
   logic [1:0]  status, next_status;
   logic [1:0]  mask, next_mask;
   logic        half_div, next_half_div;
   logic        wrap_pending, next_wrap_pending;
   logic        aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        next_bvalid;
   bt16_pkg::bt16_rd_state_t rd_state, next_rd_state;
   logic [31:0] next_rdata;
   logic        wr_fire, rd_fire, tick, src_tick, running, match_evt, gate_evt;
   logic [15:0] ctrl_word, ctrl_merged;

   assign ctrl_word = {ctrl.count_on, 1'b0, ctrl.stop_in_idle, 3'h0, ctrl.ext_clock_select, 1'b0,
                       ctrl.gate_accumulate_en, ctrl.prescale_select, 1'b0, ctrl.ext_clock_sync,
                       ctrl.clock_source_select, 1'b0}; // RULE14

   // ----------------------------------------------------------------
   // clock source, prescaler and counter
   // ----------------------------------------------------------------
   always_comb begin
      next_half_div = ~half_div;
      src_tick      = 1'b0;
      if (!ctrl.clock_source_select) begin // RULE11
         // internal clock is half the oscillator rate
         src_tick = half_div && (!ctrl.gate_accumulate_en || gate_level); // RULE8 RULE17
      end else begin
         case (ctrl.ext_clock_select) // RULE6 RULE7
            bt16_pkg::BT16_SRC_SECONDARY: src_tick = secondary_osc_rise;
            bt16_pkg::BT16_SRC_EXTPIN:    src_tick = ctrl.ext_clock_sync ? ext_rise : (ext_raw_qq & ~ext_raw_qqq); // RULE10
            bt16_pkg::BT16_SRC_LOW_POWER_RC_OSC:      src_tick = low_power_rc_osc_rise;
            default:                      src_tick = 1'b0;
         endcase
      end
      // async counting keeps going in sleep; synchronous modes stop with the system
      running = ctrl.count_on && !(cpu_idle && ctrl.stop_in_idle) // RULE3 RULE4 RULE5
                && !(cpu_sleep && !(ctrl.clock_source_select && !ctrl.ext_clock_sync));
      tick         = 1'b0;
      next_ps_cnt  = ps_cnt;
      if (running && src_tick) begin // RULE9
         if (ps_cnt >= ps_limit(ctrl.prescale_select)) begin
            next_ps_cnt = 9'h000;
            tick        = 1'b1;
         end else begin
            next_ps_cnt = ps_cnt + 9'h001;
         end
      end
      next_count        = count;
      next_wrap_pending = wrap_pending;
      match_evt         = 1'b0;
      if (tick) begin // RULE1 RULE16
         if (wrap_pending) begin
            next_count        = 16'h0000;
            next_wrap_pending = 1'b0;
         end else begin
            next_count = count + 16'h0001;
         end
         if (next_count == period_value) begin // RULE13
            next_wrap_pending = 1'b1;
            match_evt         = 1'b1;
         end
      end
      gate_evt = ctrl.count_on && !ctrl.clock_source_select && ctrl.gate_accumulate_en && gate_fall; // RULE17
   end

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = (rd_state == bt16_pkg::BT16_RD_IDLE);
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_comb begin
      ctrl_merged  = merge16(ctrl_word, w_data, w_strb);
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid && !s_axi_bready;
      next_ctrl    = ctrl;
      next_period_value = period_value;
      next_mask    = mask;
      next_status  = status;
      next_rd_state = rd_state;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         case (aw_addr)
            `BT16_OFF_CONTROL: next_ctrl = bt16_pkg::bt16_ctrl_t'({ctrl_merged[15], ctrl_merged[13],
               ctrl_merged[9:8], ctrl_merged[6], ctrl_merged[5:4], ctrl_merged[2:1]}); // RULE15
            `BT16_OFF_PERIOD: next_period_value = merge16(period_value, w_data, w_strb); // RULE13
            `BT16_OFF_MASK:   next_mask = w_strb[0] ? w_data[1:0] : mask;
            default: ;
         endcase
      end
      case (rd_state)
         bt16_pkg::BT16_RD_IDLE: begin
            if (rd_fire) begin
               next_rd_state = bt16_pkg::BT16_RD_RESP;
               case (s_axi_araddr)
                  `BT16_OFF_CONTROL: next_rdata = {16'h0000, ctrl_word};
                  `BT16_OFF_PERIOD:  next_rdata = {16'h0000, period_value};
                  `BT16_OFF_COUNT:   next_rdata = {16'h0000, count};
                  `BT16_OFF_STATUS: begin
                     next_rdata  = {30'h0, status};
                     next_status = 2'h0; // read clears
                  end
                  `BT16_OFF_MASK:    next_rdata = {30'h0, mask};
                  default:           next_rdata = 32'h0000_0000;
               endcase
            end
         end
         bt16_pkg::BT16_RD_RESP: begin
            if (s_axi_rready) begin
               next_rd_state = bt16_pkg::BT16_RD_IDLE;
            end
         end
         default: next_rd_state = bt16_pkg::BT16_RD_IDLE;
      endcase
      // events set after the clear so a coincident event is kept
      if (match_evt) begin // RULE2
         next_status[`BT16_ST_MATCH] = 1'b1;
      end
      if (gate_evt) begin // RULE2
         next_status[`BT16_ST_GATE] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl         <= bt16_pkg::bt16_ctrl_t'(9'h000);
         period_value <= `BT16_PERIOD_RST;
         count        <= 16'h0000;
         ps_cnt       <= 9'h000;
         status       <= 2'h0;
         mask         <= 2'h0;
         half_div     <= 1'b0;
         wrap_pending <= 1'b0;
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         rd_state     <= bt16_pkg::BT16_RD_IDLE;
         s_axi_rdata  <= 32'h0000_0000;
         ext_raw_q    <= 1'b0;
         ext_raw_qq   <= 1'b0;
         ext_raw_qqq  <= 1'b0;
      end else begin
         ctrl         <= next_ctrl;
         period_value <= next_period_value;
         count        <= next_count;
         ps_cnt       <= next_ps_cnt;
         status       <= next_status;
         mask         <= next_mask;
         half_div     <= next_half_div;
         wrap_pending <= next_wrap_pending;
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         rd_state     <= next_rd_state;
         s_axi_rdata  <= next_rdata;
         // unsynchronised path: three sampling flops without the agreement filter, a cycle faster
         ext_raw_q    <= external_clock_pin;
         ext_raw_qq   <= ext_raw_q;
         ext_raw_qqq  <= ext_raw_qq;
      end
   end

   assign s_axi_bresp = 2'h0;
   assign s_axi_rresp = 2'h0;
   assign s_axi_rvalid = (rd_state == bt16_pkg::BT16_RD_RESP);
   assign irq = |(status & mask);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_off_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      !ctrl.count_on |=> $stable(count)) else $error("count moved while off");
   a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      (ctrl.stop_in_idle && cpu_idle) |=> $stable(count)) else $error("count moved in idle");
   a_match_flag: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
      match_evt |=> status[0]) else $error("match flag missing");
   a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
      (tick && wrap_pending) |=> count == 16'h0000) else $error("no wrap to zero");
   a_gate_flag: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
      gate_evt |=> status[1]) else $error("gate flag missing");
   a_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
      (!ctrl.clock_source_select && ctrl.gate_accumulate_en && !gate_level && !wrap_pending)
      |=> $stable(count)) else $error("count moved with gate low");
   a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
      (ctrl_word & ~`BT16_CONTROL_MASK) == 16'h0000) else $error("reserved bit set");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      match_evt && mask[0] |=> irq) else $error("irq not raised");
   a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_fire |=> s_axi_rvalid) else $error("read not answered");
   c_match: cover property (@(posedge aclk) disable iff (!aresetn) match_evt);
   c_gate: cover property (@(posedge aclk) disable iff (!aresetn) gate_evt);
   c_ext: cover property (@(posedge aclk) disable iff (!aresetn) tick && ctrl.clock_source_select);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule
`default_nettype wire

/* File: verif/bt16_pin_model.sv */
/*
 far side of the timer pins: bursts on one clock source pin, and the gate level.
 assumes requests arrive just after an aclk rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bt16_pin_model (
   input  wire logic       aclk,    // system clock
   input  wire logic [1:0] pin_sel, // source to pulse, 3 pulses none
   input  wire logic       go,      // start a burst
   input  wire logic [7:0] n_edges, // rising edges per burst
   input  wire logic       gate_in, // wanted gate level
   output logic            busy,    // burst running
   output logic [2:0]      src,     // secondary, external pin, low_power_rc_osc
   output logic            gate     // gate pin
);
   logic [7:0] left = 8'h00;
   logic [2:0] ph   = 3'h0;
   // three-cycle pulses every six cycles so the synced and the raw path both see every edge
   always @(posedge aclk) begin
      if (go) begin
         left <= n_edges;
         ph   <= 3'h0;
      end else if (left != 8'h00) begin
         ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         if (ph == 3'h5) begin
            left <= left - 8'h01;
         end
      end
   end
   // source clocks stand low between bursts
   assign src  = (left != 8'h00 && ph < 3'h3) ? (3'h1 << pin_sel) : 3'h0;
   assign busy = (left != 8'h00);
   assign gate = gate_in;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
/*
 self-checking bench of the 16-bit timer: axi4-lite master tasks, one task per scenario.
 assumes bt16_pin_model drives the source and gate pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bt16_consts.svh"
module testbench;
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic        idle    = 1'b0;
   logic        sleep   = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [1:0]  pin_sel = 2'h0;
   logic [7:0]  n_edges = 8'h00;
   logic        go      = 1'b0;
   logic        gate_in = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, gate, busy;
   logic [31:0] rdata, c0, c1, s;
   logic [2:0]  src;
   logic [1:0]  bresp, rresp;
   int          mismatches = 0;
   int          n_checks   = 0;

   initial begin
      forever #10 aclk = ~aclk;
   end

   bt16_timer u_dut (
      .aclk(aclk), .aresetn(aresetn), .cpu_idle(idle), .cpu_sleep(sleep), .secondary_osc(src[0]),
      .external_clock_pin(src[1]), .low_power_rc_osc(src[2]), .gate_pin(gate), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

   bt16_pin_model u_pins (.aclk(aclk), .pin_sel(pin_sel), .go(go), .n_edges(n_edges),
      .gate_in(gate_in), .busy(busy), .src(src), .gate(gate));

   // ------
   // bus and compare tasks
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rng(input logic [31:0] got, input int lo, input int hi);
      chk(32'((got >= lo && got <= hi) === 1'b1), 32'h1);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && t < 50);
      bready <= 1'b0;
      chk({29'h0, t < 50, bresp}, 32'h4);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int t;
      t = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && t < 50);
      d = rdata;
      rready <= 1'b0;
      chk({29'h0, t < 50, rresp}, 32'h4);
   endtask
   // count advance between two reads, modulo the 16-bit width
   task automatic span(input int n, output logic [31:0] d);
      rd(`BT16_OFF_COUNT, c0);
      cyc(n);
      rd(`BT16_OFF_COUNT, c1);
      d = {16'h0, c1[15:0] - c0[15:0]};
   endtask
   task automatic burst(input logic [1:0] sel, input logic [7:0] n, output logic [31:0] d);
      int t;
      t = 0;
      rd(`BT16_OFF_COUNT, c0);
      pin_sel <= sel;
      n_edges <= n;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(1);
      while (busy && t < 500) begin
         cyc(1);
         t++;
      end
      cyc(8);
      rd(`BT16_OFF_COUNT, c1);
      d = {16'h0, c1[15:0] - c0[15:0]};
   endtask

   // ------
   // scenarios
   // ------
   task automatic t_reset;
      rd(`BT16_OFF_CONTROL, s);
      chk(s, 32'h0);
      rd(`BT16_OFF_PERIOD, s);
      chk(s, 32'hFFFF);
      rd(`BT16_OFF_STATUS, s);
      chk(s, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`BT16_OFF_CONTROL, 32'hFFFFFFFF);
      rd(`BT16_OFF_CONTROL, s);
      chk(s, 32'hA376);
      wr(`BT16_OFF_CONTROL, 32'h0);
      rd(`BT16_OFF_CONTROL, s);
      chk(s, 32'h0);
      wr(8'h1C, 32'h1234);
      rd(8'h1C, s);
      chk(s, 32'h0);
   endtask
   task automatic t_match;
      int t;
      t = 0;
      wr(`BT16_OFF_CONTROL, 32'h8000);
      wr(`BT16_OFF_PERIOD, 32'h5);
      wr(`BT16_OFF_MASK, 32'h1);
      while (irq !== 1'b1 && t < 100) begin
         cyc(1);
         t++;
      end
      chk({31'h0, irq}, 32'h1);
      cyc(60);
      wr(`BT16_OFF_CONTROL, 32'h0);
      rd(`BT16_OFF_COUNT, s);
      rng(s, 0, 5);
      wr(`BT16_OFF_MASK, 32'h0);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      wr(`BT16_OFF_MASK, 32'h1);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      rd(`BT16_OFF_STATUS, s);
      chk(s, 32'h1);
      rd(`BT16_OFF_STATUS, s);
      cyc(2);
      chk(s, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_prescale;
      int          div [4] = '{1, 8, 64, 256};
      logic [31:0] d;
      wr(`BT16_OFF_PERIOD, 32'hFFFF);
      for (int k = 0; k < 4; k++) begin
         wr(`BT16_OFF_CONTROL, 32'h8304 | (32'(k) << 4));
         span(12 * div[k], d);
         rng(d, 5, 8);
      end
      wr(`BT16_OFF_CONTROL, 32'h0);
      span(40, d);
      chk(d, 32'h0);
   endtask
   task automatic t_power;
      logic [31:0] d;
      idle <= 1'b1;
      wr(`BT16_OFF_CONTROL, 32'hA000);
      span(40, d);
      chk(d, 32'h0);
      wr(`BT16_OFF_CONTROL, 32'h8000);
      span(40, d);
      rng(d, 18, 24);
      idle <= 1'b0;
      sleep <= 1'b1;
      wr(`BT16_OFF_CONTROL, 32'h8102);
      burst(2'h1, 8'h5, d);
      chk(d, 32'h5);
      sleep <= 1'b0;
   endtask
   task automatic t_ext;
      logic [31:0] d;
      gate_in <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(`BT16_OFF_CONTROL, 32'h8046 | (32'(i) << 8));
         burst((i == 3) ? 2'h1 : 2'(i), 8'h4, d);
         chk(d, (i == 3) ? 32'h0 : 32'h4);
         gate_in <= 1'b0;
      end
      rd(`BT16_OFF_STATUS, s);
      chk(s, 32'h0);
   endtask
   task automatic t_gate;
      logic [31:0] d;
      wr(`BT16_OFF_MASK, 32'h2);
      wr(`BT16_OFF_CONTROL, 32'h8040);
      span(20, d);
      chk(d, 32'h0);
      gate_in <= 1'b1;
      cyc(40);
      gate_in <= 1'b0;
      cyc(8);
      chk({31'h0, irq}, 32'h1);
      rd(`BT16_OFF_COUNT, c0);
      rng({16'h0, c0[15:0] - c1[15:0]}, 18, 22);
      wr(`BT16_OFF_CONTROL, 32'h0);
      rd(`BT16_OFF_STATUS, s);
      chk(s, 32'h2);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      cyc(20000);
      mismatches++;
      summarize();
   end

   initial begin
      cyc(6);
      aresetn <= 1'b1;
      cyc(1);
      t_reset();
      t_match();
      t_prescale();
      t_power();
      t_ext();
      t_gate();
      summarize();
   end
endmodule
`default_nettype wire
